// *** verilog/pao_pkg.sv ***
// constants and carrier types for the pipelined converter output path
// Notes on behaviour
// - each result is one 12-bit parallel word, top bit most significant
// - float input high takes the result word off drive; low drives it; stream_data is not gated
// - invert input high flips only the top output bit; low gives straight code
// - result valid 6.5 convert-clock cycles after its start edge, one per cycle
// - quantizer is 11 stages: ten make a three-level decision on a doubled residue, the last takes two bits
// - stages advance on both convert-clock edges, two stages per cycle
// - stage digits are delay-aligned then combined with redundancy into 12 bits
// - non-overlapping two phases: track in first, hold in second
// - full-scale positive input gives all ones in straight offset binary
package pao_pkg;

	// ------------------------------------------------------------
	// sizes and positions
	// ------------------------------------------------------------
	localparam int RESULT_W = 12;
	localparam int NSTG = 11;
	localparam int DIG_W = 2 * NSTG;
	localparam int RESULT_BIT_TOP = 11;
	localparam int RESULT_BIT_BOTTOM = 0;
	localparam int FIFO_DEPTH = 8;
	localparam int LAT_HALF = 13;

	// ------------------------------------------------------------
	// stage thresholds and reconstruction steps
	// ------------------------------------------------------------
	localparam logic [11:0] TH_LO = 12'h600;
	localparam logic [11:0] TH_HI = 12'ha00;
	localparam logic [12:0] STEP_ONE = 13'h0800;
	localparam logic [12:0] STEP_TWO = 13'h1000;
	localparam logic [11:0] CODE_MAX = 12'hfff;
	localparam logic [11:0] WORD_RST = 12'h000;

	// ------------------------------------------------------------
	// one pipeline slot
	// ------------------------------------------------------------
	typedef struct packed {
		logic vld;
		logic [RESULT_W-1:0] res;
		logic [DIG_W-1:0] dig;
		logic [RESULT_W-1:0] smp;
	} pao_slot_s;

endpackage

// *** verilog/pao_fifo.sv ***
// word buffer with valid and ready on both sides
`timescale 1ns/1ps
module pao_fifo #(
	parameter int W = 12,
	parameter int DEPTH = 8
) (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [W-1:0] mem [0:DEPTH-1];
	logic [AW-1:0] wr_r;
	logic [AW-1:0] rd_r;
	logic [AW:0] cnt_r;
	logic push;
	logic pop;

	// ------------------------------------------------------------
	// flags
	// ------------------------------------------------------------
	assign in_ready = cnt_r != (AW+1)'(DEPTH);
	assign out_valid = cnt_r != '0;
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem[rd_r];

	// ------------------------------------------------------------
	// storage and pointers
	// ------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (push) begin
			mem[wr_r] <= in_data;
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			wr_r <= '0;
			rd_r <= '0;
			cnt_r <= '0;
		end else begin
			if (push) begin
				wr_r <= (wr_r == AW'(DEPTH-1)) ? '0 : wr_r + 1'b1;
			end
			if (pop) begin
				rd_r <= (rd_r == AW'(DEPTH-1)) ? '0 : rd_r + 1'b1;
			end
			if (push && !pop) begin
				cnt_r <= cnt_r + 1'b1;
			end else if (pop && !push) begin
				cnt_r <= cnt_r - 1'b1;
			end
		end
	end

	a_fifo_bound: assert property (@(posedge mclk) disable iff (sys_rst) cnt_r <= (AW+1)'(DEPTH))
		else $error("fifo count above depth");

endmodule

// *** verilog/pao_core.sv ***
// converter digital path: phases, stage pipeline, correction, output word, buffer
`timescale 1ns/1ps
module pao_core #(
	parameter int BUF_DEPTH = pao_pkg::FIFO_DEPTH
) (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic conv_clk,
	input wire logic [11:0] analog_sample,
	input wire logic output_float,
	input wire logic top_bit_invert,
	output logic [11:0] result_word,
	output logic result_oe,
	output logic data_valid,
	output logic word_strobe,
	output logic stream_valid,
	input wire logic stream_ready,
	output logic [11:0] stream_data,
	output logic buf_ready,
	output logic overrun
);
	localparam int NS = pao_pkg::NSTG;

	logic clk_s_r;
	logic clk_d_r;
	logic phi1;
	logic phi2;
	logic fall;
	logic sub_en;
	logic [11:0] track_r;
	pao_pkg::pao_slot_s slot_r [0:NS+1];
	pao_pkg::pao_slot_s slot_nxt [1:NS];
	logic [11:0] word_r;
	logic [11:0] out_smp_r;
	logic strobe_r;
	logic valid_r;
	logic oe_r;
	logic [pao_pkg::LAT_HALF-1:0] hist_r;

	// ------------------------------------------------------------
	// stage step: two-bit decision and residue
	// ------------------------------------------------------------
	function automatic pao_pkg::pao_slot_s stage_step(input pao_pkg::pao_slot_s s, input logic last);
		logic [1:0] d;
		logic [12:0] dbl;
		logic [12:0] sub;
		pao_pkg::pao_slot_s o;
		o = s;
		dbl = {s.res, 1'b0};
		if (last) begin
			d = s.res[11:10];
		end else if (s.res < pao_pkg::TH_LO) begin
			d = 2'h0;
		end else if (s.res < pao_pkg::TH_HI) begin
			d = 2'h1;
		end else begin
			d = 2'h2;
		end
		sub = (d == 2'h2) ? pao_pkg::STEP_TWO : (d == 2'h1) ? pao_pkg::STEP_ONE : 13'h0000;
		o.res = last ? s.res : 12'(dbl - sub);
		o.dig = {s.dig[pao_pkg::DIG_W-3:0], d};
		return o;
	endfunction

	// ------------------------------------------------------------
	// correction: weighted sum of aligned digits
	// ------------------------------------------------------------
	function automatic logic [11:0] correct(input logic [pao_pkg::DIG_W-1:0] dig);
		logic [12:0] acc;
		acc = 13'h0000;
		for (int j = 0; j < NS; j++) begin
			acc = acc + (13'(dig[2*j +: 2]) << j);
		end
		return acc[12] ? pao_pkg::CODE_MAX : acc[11:0];
	endfunction

	// ------------------------------------------------------------
	// clock edges and two phases
	// ------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			clk_s_r <= 1'b0;
			clk_d_r <= 1'b0;
		end else begin
			clk_s_r <= conv_clk;
			clk_d_r <= clk_s_r;
		end
	end

	assign phi1 = clk_s_r && clk_d_r;
	assign phi2 = !clk_s_r && !clk_d_r;
	assign fall = clk_d_r && !clk_s_r;
	assign sub_en = clk_s_r ^ clk_d_r;

	// track follows the input in the first phase
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			track_r <= 12'h000;
		end else if (phi1) begin
			track_r <= analog_sample;
		end
	end

	// ------------------------------------------------------------
	// hold slot, stages and correction slot
	// ------------------------------------------------------------
	for (genvar k = 1; k <= NS; k++) begin : g_stg
		assign slot_nxt[k] = stage_step(slot_r[k-1], k == NS);
		if (k < NS) begin : g_chk
			a_stage_digit: assert property (@(posedge mclk) disable iff (sys_rst)
				slot_r[k].vld |-> slot_r[k].dig[1:0] != 2'h3)
				else $error("redundant stage produced digit three");
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			for (int k = 0; k <= NS + 1; k++) begin
				slot_r[k] <= '0;
			end
		end else if (sub_en) begin
			slot_r[0].vld <= fall;
			slot_r[0].res <= track_r;
			slot_r[0].dig <= '0;
			slot_r[0].smp <= track_r;
			for (int k = 1; k <= NS; k++) begin
				slot_r[k] <= slot_nxt[k];
			end
			slot_r[NS+1].vld <= slot_r[NS].vld;
			slot_r[NS+1].res <= correct(slot_r[NS].dig);
			slot_r[NS+1].dig <= slot_r[NS].dig;
			slot_r[NS+1].smp <= slot_r[NS].smp;
		end
	end

	// ------------------------------------------------------------
	// output word
	// ------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			word_r <= pao_pkg::WORD_RST;
			out_smp_r <= 12'h000;
			strobe_r <= 1'b0;
			valid_r <= 1'b0;
		end else begin
			strobe_r <= sub_en && slot_r[NS+1].vld;
			if (sub_en && slot_r[NS+1].vld) begin
				word_r <= slot_r[NS+1].res ^ {top_bit_invert, 11'h000};
				out_smp_r <= slot_r[NS+1].smp;
				valid_r <= 1'b1;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			oe_r <= 1'b0;
		end else begin
			oe_r <= !output_float;
		end
	end

	assign result_word = word_r;
	assign result_oe = oe_r;
	assign data_valid = valid_r;
	assign word_strobe = strobe_r;

	// ------------------------------------------------------------
	// result buffer
	// ------------------------------------------------------------
	pao_fifo #(
		.W(pao_pkg::RESULT_W),
		.DEPTH(BUF_DEPTH)
	) u_buf (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.in_valid(strobe_r),
		.in_ready(buf_ready),
		.in_data(word_r),
		.out_valid(stream_valid),
		.out_ready(stream_ready),
		.out_data(stream_data)
	);

	assign overrun = strobe_r && !buf_ready;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			hist_r <= '0;
		end else if (sub_en) begin
			hist_r <= {hist_r[pao_pkg::LAT_HALF-2:0], fall};
		end
	end

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (sys_rst);

	a_latency_half: assert property (sub_en && hist_r[pao_pkg::LAT_HALF-1] |=> word_strobe)
		else $error("result not out thirteen half cycles after start");
	a_no_early: assert property (word_strobe |-> $past(hist_r[pao_pkg::LAT_HALF-1]))
		else $error("result without a start thirteen half cycles back");
	a_word_order: assert property (word_strobe |->
		result_word[pao_pkg::RESULT_BIT_BOTTOM +: 11] == out_smp_r[10:0])
		else $error("low result bits do not match the sample");
	a_top_invert: assert property (word_strobe |->
		result_word[pao_pkg::RESULT_BIT_TOP] == (out_smp_r[11] ^ $past(top_bit_invert)))
		else $error("top bit inversion wrong");
	a_float_off: assert property (output_float |=> !result_oe)
		else $error("outputs driven while float high");
	a_float_on: assert property (!output_float |=> result_oe)
		else $error("outputs not driven while float low");
	a_code_exact: assert property (slot_r[NS+1].vld |-> slot_r[NS+1].res == slot_r[NS+1].smp)
		else $error("corrected code differs from held sample");
	a_full_scale: assert property (slot_r[NS+1].vld && slot_r[NS+1].smp == pao_pkg::CODE_MAX
		|-> slot_r[NS+1].res == pao_pkg::CODE_MAX)
		else $error("full scale not all ones");
	a_phase_excl: assert property (!(phi1 && phi2) && !(phi1 && sub_en))
		else $error("phases overlap");
	a_hold_src: assert property (sub_en && fall |=> slot_r[0].smp == $past(track_r) && slot_r[0].vld)
		else $error("hold slot not loaded from tracked value");
	a_track_freeze: assert property (!phi1 |=> track_r == $past(track_r))
		else $error("tracked value moved outside the first phase");
	a_stage_move: assert property (sub_en |=> slot_r[1].vld == $past(slot_r[0].vld))
		else $error("stage did not advance on edge");
	a_fill_flag: assert property (word_strobe |-> data_valid)
		else $error("word out before valid flag");

endmodule

// *** verif/pao_capture.sv ***
// capture-side model: convert clock source and word latch
`timescale 1ns/1ps
module pao_capture (
	input wire logic mclk,
	input wire logic run,
	input wire logic [7:0] half,
	input wire logic [11:0] base,
	input wire logic [11:0] stride,
	input wire logic word_strobe,
	input wire logic [11:0] result_word,
	output logic conv_clk,
	output logic [11:0] analog_sample,
	output logic [11:0] got_word,
	output int got_cnt
);
	int ph = 0;
	int idx = 0;

	// ----------
	// equal halves, parked high between frames
	// ----------
	initial begin
		conv_clk = 1'b1;
		analog_sample = 12'h000;
		got_word = 12'h000;
		got_cnt = 0;
	end
	always @(negedge mclk) begin
		if (!run && conv_clk) begin
			ph = 0;
			idx = 0;
			analog_sample = base;
		end else begin
			ph = ph + 1;
			if (ph >= int'(half)) begin
				ph = 0;
				conv_clk = !conv_clk;
				if (conv_clk) begin
					idx = idx + 1;
					analog_sample = base + 12'(idx) * stride;
				end
			end
		end
	end

	// ----------
	// latch each new word
	// ----------
	always @(posedge mclk) begin
		if (word_strobe) begin
			got_word <= result_word;
			got_cnt <= got_cnt + 1;
		end
	end
endmodule

// *** verif/pipelined_adc_output_path_tb.sv ***
// self-checking bench for the converter output path
`timescale 1ns/1ps
module pipelined_adc_output_path_tb;
	logic mclk, sys_rst, output_float, top_bit_invert, stream_ready, run, conv_clk;
	logic result_oe, data_valid, word_strobe, stream_valid, buf_ready, overrun;
	logic [7:0] half;
	logic [11:0] base, stride, result_word, stream_data, got_word, analog_sample;
	int got_cnt, c0;
	int miscompares = 0;
	int compares = 0;
	int cycles = 0;

	pao_core #(.BUF_DEPTH(8)) DUT (.mclk(mclk), .sys_rst(sys_rst), .conv_clk(conv_clk),
		.analog_sample(analog_sample), .output_float(output_float), .top_bit_invert(top_bit_invert),
		.result_word(result_word), .result_oe(result_oe), .data_valid(data_valid), .word_strobe(word_strobe),
		.stream_valid(stream_valid), .stream_ready(stream_ready), .stream_data(stream_data),
		.buf_ready(buf_ready), .overrun(overrun));
	pao_capture u_cap (.mclk(mclk), .run(run), .half(half), .base(base), .stride(stride),
		.word_strobe(word_strobe), .result_word(result_word), .conv_clk(conv_clk),
		.analog_sample(analog_sample), .got_word(got_word), .got_cnt(got_cnt));

	// ----------
	// helpers
	// ----------
	task automatic close_out;
		if (miscompares == 0 && compares > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic check(input logic [11:0] seen, input logic [11:0] exp, input string what);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected at %0t: %s seen %h want %h", $time, what, seen, exp);
		end
	endtask
	function automatic logic [11:0] smp(input int k);
		return base + 12'(k) * stride;
	endfunction
	task automatic restart(input logic [7:0] h, input logic [11:0] b, input logic [11:0] s, input logic inv);
		run = 0;
		repeat (40) @(negedge mclk);
		half = h;
		base = b;
		stride = s;
		top_bit_invert = inv;
		sys_rst = 1;
		repeat (2) @(negedge mclk);
		sys_rst = 0;
		@(negedge mclk);
		c0 = got_cnt;
	endtask

	// ----------
	// scenarios
	// ----------
	task automatic t_latency;
		int n;
		restart(8'd4, 12'h123, 12'h111, 1'b0);
		check(12'(data_valid), 12'h000, "valid early");
		check(result_word, 12'h000, "word early");
		run = 1;
		@(negedge conv_clk);
		n = 0;
		while (word_strobe !== 1'b1 && n < 200) begin
			@(posedge mclk);
			n++;
			@(negedge mclk);
		end
		check(12'(n), 12'(13 * 4 + 2), "latency");
		check(result_word, 12'h123, "first word");
		check(12'(data_valid), 12'h001, "valid");
		n = 0;
		do begin
			@(posedge mclk);
			n++;
			@(negedge mclk);
		end while (word_strobe !== 1'b1 && n < 200);
		check(12'(n), 12'h008, "spacing");
		check(result_word, 12'h234, "second word");
		run = 0;
	endtask
	task automatic t_words(input logic [11:0] b, input logic [11:0] s, input logic inv);
		int k = 0;
		int t = 0;
		restart(8'd2, b, s, inv);
		stream_ready = 1;
		run = 1;
		while (k < 10 && t < 2000) begin
			@(negedge mclk);
			t++;
			if (got_cnt - c0 > k) begin
				check(got_word, smp(k) ^ {inv, 11'h000}, "word");
				k++;
			end
		end
		check(12'(k), 12'h00a, "word count");
	endtask
	task automatic t_float;
		restart(8'd2, 12'h000, 12'h001, 1'b0);
		output_float = 1;
		@(negedge mclk);
		check(12'(result_oe), 12'h000, "float");
		output_float = 0;
		@(negedge mclk);
		check(12'(result_oe), 12'h001, "drive");
	endtask
	task automatic t_fifo;
		int k = 0;
		int t = 0;
		bit ovr = 0;
		restart(8'd2, 12'h0a5, 12'h13b, 1'b0);
		stream_ready = 0;
		run = 1;
		while (got_cnt - c0 < 10 && t < 2000) begin
			@(negedge mclk);
			t++;
			if (overrun === 1'b1) ovr = 1;
		end
		run = 0;
		// the clock finishes its period and one more word reaches the full buffer and is dropped
		repeat (8) @(negedge mclk);
		check(12'(buf_ready), 12'h000, "full");
		check(12'(ovr), 12'h001, "overrun");
		for (t = 0; t < 40; t++) begin
			@(negedge mclk);
			if (stream_valid === 1'b1) begin
				check(stream_data, smp(k), "drain");
				k++;
			end
			stream_ready = 1;
		end
		check(12'(k), 12'h008, "depth");
		check(12'(buf_ready), 12'h001, "empty");
	endtask

	// ----------
	// clock, watchdog, main
	// ----------
	initial begin
		mclk = 0;
		forever #10 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			close_out();
		end
	end
	initial begin
		sys_rst = 1;
		output_float = 0;
		top_bit_invert = 0;
		stream_ready = 0;
		run = 0;
		half = 8'd2;
		base = 12'h000;
		stride = 12'h001;
		repeat (16) @(negedge mclk);
		sys_rst = 0;
		t_latency();
		t_words(12'hfff, 12'h3a5, 1'b0);
		t_words(12'hfff, 12'h3a5, 1'b1);
		t_words(12'h000, 12'h801, 1'b0);
		t_float();
		t_fifo();
		close_out();
	end
endmodule
